// *** design/acq_pkg.sv ***
// Constants shared by the acquisition configuration register bank
package acq_pkg;

  // Clock and timing
  localparam int CLK_HZ        = 25_000_000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int RATE_50_HZ    = 1600;
  localparam int RATE_60_HZ    = 1920;
  localparam int OSR_50_CYCLES = CLK_HZ / RATE_50_HZ;
  localparam int OSR_60_CYCLES = CLK_HZ / RATE_60_HZ;
  localparam int STEP_US       = 96;
  localparam int STEP_CYCLES   = (STEP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register indices; byte address is four times the index
  localparam logic [7:0] ACQ_CFG_IDX  = 8'h62;
  localparam logic [7:0] BAL_DLY_IDX  = 8'h63;
  localparam logic [7:0] STATUS_IDX   = 8'h70;
  localparam logic [7:0] MASK_IDX     = 8'h71;
  localparam logic [7:0] CONTEXT_IDX  = 8'h72;

  // Reset values
  localparam logic [15:0] ACQ_CFG_RST = 16'h0000;
  localparam logic [15:0] BAL_DLY_RST = 16'h0000;
  localparam logic [9:0]  CONTEXT_RST = 10'h000;

  // Acquisition configuration fields
  localparam int ACQ_STUCK_BIT  = 15;
  localparam int ACQ_CAL_BIT    = 14;
  localparam int ACQ_COMP_BIT   = 13;
  localparam int ACQ_RATE_LSB   = 11;
  localparam int ACQ_THRM_LSB   = 9;
  localparam logic [15:0] ACQ_WR_MASK = 16'hFE00;

  // Recovery delay fields
  localparam int DLY_CELL_LSB = 8;
  localparam int DLY_SW_LSB   = 0;

  // Sequence context fields
  localparam int CTX_SCAN_LSB = 0;
  localparam int CTX_OSR_LSB  = 3;
  localparam int CTX_ASD_BIT  = 6;
  localparam int CTX_ALT_BIT  = 7;
  localparam int CTX_CBM_LSB  = 8;

  // Status and mask bits
  localparam int STATUS_W  = 5;
  localparam int EV_ZS     = 0;
  localparam int EV_FS     = 1;
  localparam int EV_OV     = 2;
  localparam int EV_UV     = 3;
  localparam int EV_REC    = 4;

  // Scan types and self-test expectations
  localparam logic [2:0]  SCAN_COMP_ONLY = 3'h2;
  localparam logic [2:0]  SCAN_BOTH      = 3'h1;
  localparam logic [2:0]  OSR_OFF        = 3'h0;
  localparam logic [11:0] ADC_ZERO       = 12'h000;
  localparam logic [11:0] ADC_FULL       = 12'hFFF;
  localparam logic [1:0]  THRM_OFF       = 2'h2;
  localparam logic [1:0]  THRM_ON        = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ZERO = 3'h1,
    ST_FULL = 3'h3,
    ST_COMP = 3'h2,
    ST_DONE = 3'h6
  } test_state_e;

endpackage

// *** design/acquisition_config_regs.sv ***
// Acquisition configuration and balancing recovery delay register bank
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/100ps
module acquisition_config_regs #(
  parameter int OSR_50_CYCLES = acq_pkg::OSR_50_CYCLES,
  parameter int OSR_60_CYCLES = acq_pkg::OSR_60_CYCLES
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Sequencer handshake
  input  wire logic        seq_end,
  input  wire logic        acquisition_active,
  input  wire logic        fast_sample_ready,
  input  wire logic [11:0] adc_result,
  input  wire logic        adc_result_valid,
  input  wire logic        comp_result_valid,
  input  wire logic        comp_above_upper,
  input  wire logic        comp_below_lower,
  // Balancing controller
  input  wire logic        manual_measure_req,
  input  wire logic        auto_pair_done,
  // Analog controls
  output logic             adc_force_zero,
  output logic             adc_force_full,
  output logic             comp_test_run,
  output logic             cal_apply,
  output logic             thermistor_switch_on,
  output logic             osr_sample_strobe,
  output logic             recovery_busy,
  output logic             recovery_done,
  // Interrupt
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset synchroniser

  logic rst_meta_r;
  logic rst_sync_n;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_n <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage and bus decode

  function automatic logic [9:0] reg_addr(input logic [7:0] idx);
    reg_addr = {idx, 2'b00};
  endfunction

  logic [15:0]                   acq_r;
  logic [15:0]                   dly_r;
  logic [9:0]                    ctx_r;
  logic [acq_pkg::STATUS_W-1:0]  status_r;
  logic [acq_pkg::STATUS_W-1:0]  mask_r;
  logic [acq_pkg::STATUS_W-1:0]  events;
  logic [31:0]                   rd_mux;
  logic                          wr_go;
  logic                          hit_acq;
  logic                          hit_dly;
  logic                          hit_status;
  logic                          hit_mask;
  logic                          hit_ctx;

  // Every access answers after exactly one wait cycle
  assign wr_go = avs_write && !avs_waitrequest;

  always_comb
  begin
    hit_acq    = 1'b0;
    hit_dly    = 1'b0;
    hit_status = 1'b0;
    hit_mask   = 1'b0;
    hit_ctx    = 1'b0;
    if (avs_address == reg_addr(acq_pkg::ACQ_CFG_IDX))
      hit_acq = 1'b1;
    else if (avs_address == reg_addr(acq_pkg::BAL_DLY_IDX))
      hit_dly = 1'b1;
    else if (avs_address == reg_addr(acq_pkg::STATUS_IDX))
      hit_status = 1'b1;
    else if (avs_address == reg_addr(acq_pkg::MASK_IDX))
      hit_mask = 1'b1;
    else if (avs_address == reg_addr(acq_pkg::CONTEXT_IDX))
      hit_ctx = 1'b1;
  end

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit_acq)
      rd_mux = {16'h0000, acq_r};
    else if (hit_dly)
      rd_mux = {16'h0000, dly_r};
    else if (hit_status)
      rd_mux = {27'h0000000, status_r};
    else if (hit_mask)
      rd_mux = {27'h0000000, mask_r};
    else if (hit_ctx)
      rd_mux = {22'h000000, ctx_r};
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      avs_waitrequest <= 1'b1;
    else if (avs_waitrequest && (avs_read || avs_write))
      avs_waitrequest <= 1'b0;
    else
      avs_waitrequest <= 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read && avs_waitrequest)
      avs_readdata <= rd_mux;
  end

  // Only bits 15:9 exist; the rest stay zero whatever is written
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      acq_r <= acq_pkg::ACQ_CFG_RST;
    else if (wr_go && hit_acq && avs_byteenable[1])
      acq_r <= {avs_writedata[15:8], 8'h00} & acq_pkg::ACQ_WR_MASK;
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      dly_r <= acq_pkg::BAL_DLY_RST;
    else if (wr_go && hit_dly)
    begin
      if (avs_byteenable[1])
        dly_r[15:8] <= avs_writedata[15:8];
      if (avs_byteenable[0])
        dly_r[7:0] <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      ctx_r <= acq_pkg::CONTEXT_RST;
    else if (wr_go && hit_ctx)
    begin
      if (avs_byteenable[1])
        ctx_r[9:8] <= avs_writedata[9:8];
      if (avs_byteenable[0])
        ctx_r[7:0] <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      mask_r <= '0;
    else if (wr_go && hit_mask && avs_byteenable[0])
      mask_r <= avs_writedata[acq_pkg::STATUS_W-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field views

  logic       stuck_en;
  logic       comp_acc_en;
  logic [1:0] oversample_freq_sel;
  logic [1:0] thrm_mode;
  logic [2:0] scan_type;
  logic [2:0] osr_ratio;
  logic       auto_sw_dis;
  logic       alt_mux_sel;
  logic [1:0] bal_meas_en;

  assign stuck_en    = acq_r[acq_pkg::ACQ_STUCK_BIT];
  assign comp_acc_en = acq_r[acq_pkg::ACQ_COMP_BIT];
  assign oversample_freq_sel = acq_r[acq_pkg::ACQ_RATE_LSB +: 2];
  assign thrm_mode   = acq_r[acq_pkg::ACQ_THRM_LSB +: 2];
  assign scan_type   = ctx_r[acq_pkg::CTX_SCAN_LSB +: 3];
  assign osr_ratio   = ctx_r[acq_pkg::CTX_OSR_LSB +: 3];
  assign auto_sw_dis = ctx_r[acq_pkg::CTX_ASD_BIT];
  assign alt_mux_sel = ctx_r[acq_pkg::CTX_ALT_BIT];
  assign bal_meas_en = ctx_r[acq_pkg::CTX_CBM_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // End-of-sequence self-test

  acq_pkg::test_state_e state_r;
  acq_pkg::test_state_e state_nxt;
  logic                 comp_due_r;
  logic                 adc_due;
  logic                 comp_due;

  // Scan type 010 never touches the ADC, so its stuck test is skipped
  assign adc_due  = stuck_en && (scan_type != acq_pkg::SCAN_COMP_ONLY);
  assign comp_due = comp_acc_en && ((scan_type == acq_pkg::SCAN_BOTH) ||
                    (scan_type == acq_pkg::SCAN_COMP_ONLY));

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      acq_pkg::ST_IDLE:
        if (seq_end)
        begin
          if (adc_due)
            state_nxt = acq_pkg::ST_ZERO;
          else if (comp_due)
            state_nxt = acq_pkg::ST_COMP;
        end
      acq_pkg::ST_ZERO:
        if (adc_result_valid)
          state_nxt = acq_pkg::ST_FULL;
      acq_pkg::ST_FULL:
        if (adc_result_valid)
          state_nxt = comp_due_r ? acq_pkg::ST_COMP : acq_pkg::ST_DONE;
      acq_pkg::ST_COMP:
        if (comp_result_valid)
          state_nxt = acq_pkg::ST_DONE;
      default:
        state_nxt = acq_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      state_r <= acq_pkg::ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // Comparator decision is frozen at sequence end
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      comp_due_r <= 1'b0;
    else if ((state_r == acq_pkg::ST_IDLE) && seq_end)
      comp_due_r <= comp_due;
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      adc_force_zero <= 1'b0;
      adc_force_full <= 1'b0;
      comp_test_run  <= 1'b0;
    end
    else
    begin
      adc_force_zero <= (state_nxt == acq_pkg::ST_ZERO);
      adc_force_full <= (state_nxt == acq_pkg::ST_FULL);
      comp_test_run  <= (state_nxt == acq_pkg::ST_COMP);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events, status and interrupt

  logic rec_done_w;

  always_comb
  begin
    events = '0;
    events[acq_pkg::EV_ZS] = (state_r == acq_pkg::ST_ZERO) && adc_result_valid &&
                             (adc_result != acq_pkg::ADC_ZERO);
    events[acq_pkg::EV_FS] = (state_r == acq_pkg::ST_FULL) && adc_result_valid &&
                             (adc_result != acq_pkg::ADC_FULL);
    events[acq_pkg::EV_OV] = (state_r == acq_pkg::ST_COMP) && comp_result_valid &&
                             comp_above_upper;
    events[acq_pkg::EV_UV] = (state_r == acq_pkg::ST_COMP) && comp_result_valid &&
                             comp_below_lower;
    events[acq_pkg::EV_REC] = rec_done_w;
  end

  // A new event beats a simultaneous write-one-to-clear
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      status_r <= '0;
    else if (wr_go && hit_status && avs_byteenable[0])
      status_r <= (status_r & ~avs_writedata[acq_pkg::STATUS_W-1:0]) | events;
    else
      status_r <= status_r | events;
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      irq <= 1'b0;
    else
      irq <= |(status_r & mask_r);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Calibration, thermistor bias and sample rate

  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      cal_apply <= 1'b0;
    else
      cal_apply <= acq_r[acq_pkg::ACQ_CAL_BIT];
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      thermistor_switch_on <= 1'b0;
    else if (thrm_mode == acq_pkg::THRM_ON)
      thermistor_switch_on <= 1'b1;
    else if (thrm_mode == acq_pkg::THRM_OFF)
      thermistor_switch_on <= 1'b0;
    else
      thermistor_switch_on <= acquisition_active;
  end

  osr_rate_gen #(
    .P50   (OSR_50_CYCLES),
    .P60   (OSR_60_CYCLES),
    .CNT_W (14)
  ) u_rate (
    .clk        (ref_clk),
    .rst_n      (rst_sync_n),
    .sel        (oversample_freq_sel),
    .osr_active (osr_ratio != acq_pkg::OSR_OFF),
    .fast_ready (fast_sample_ready),
    .strobe_r   (osr_sample_strobe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Balancing recovery delay

  logic       manual_go;
  logic       auto_go;
  logic [7:0] dly_steps;

  assign manual_go = manual_measure_req && auto_sw_dis;
  assign auto_go   = auto_pair_done && bal_meas_en[1];

  // Unqualified requests still get a done pulse, with no wait
  always_comb
  begin
    dly_steps = 8'h00;
    if (manual_go || auto_go)
      dly_steps = alt_mux_sel ? dly_r[acq_pkg::DLY_SW_LSB +: 8]
                              : dly_r[acq_pkg::DLY_CELL_LSB +: 8];
  end

  recovery_timer #(
    .STEP  (acq_pkg::STEP_CYCLES),
    .PRE_W (12)
  ) u_timer (
    .clk    (ref_clk),
    .rst_n  (rst_sync_n),
    .start  (manual_measure_req || auto_pair_done),
    .steps  (dly_steps),
    .busy_r (recovery_busy),
    .done_r (rec_done_w)
  );

  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      recovery_done <= 1'b0;
    else
      recovery_done <= rec_done_w;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  stuck_start_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (state_r == acq_pkg::ST_IDLE && seq_end && adc_due) |-> ##1 adc_force_zero)
    else $error("stuck test did not force zero scale");

  zero_alert_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (adc_force_zero && adc_result_valid && adc_result != acq_pkg::ADC_ZERO)
    |-> ##1 status_r[acq_pkg::EV_ZS])
    else $error("zero scale alert missing");

  full_alert_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (adc_force_full && adc_result_valid && adc_result == acq_pkg::ADC_FULL &&
     !status_r[acq_pkg::EV_FS]) |-> ##1 !status_r[acq_pkg::EV_FS])
    else $error("full scale alert raised on good result");

  cal_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    ##1 (cal_apply == $past(acq_r[acq_pkg::ACQ_CAL_BIT])))
    else $error("calibration output does not track its bit");

  comp_start_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (state_r == acq_pkg::ST_IDLE && seq_end && comp_acc_en && !stuck_en &&
     scan_type == acq_pkg::SCAN_COMP_ONLY) |-> ##1 comp_test_run)
    else $error("comparator test not started");

  comp_alert_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (comp_test_run && comp_result_valid && comp_below_lower)
    |-> ##1 status_r[acq_pkg::EV_UV])
    else $error("comparator under alert missing");

  thrm_off_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (thrm_mode == acq_pkg::THRM_OFF) [*2] |-> !thermistor_switch_on)
    else $error("thermistor switch on in forced off mode");

  cell_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (manual_go && !alt_mux_sel && !recovery_busy && dly_r[15:8] != 8'h00)
    |-> ##1 recovery_busy [*8])
    else $error("cell recovery delay not inserted");

  unused_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (avs_read && !avs_waitrequest && hit_acq) |-> (avs_readdata[8:0] == 9'h000))
    else $error("unused config bits read nonzero");

endmodule

// *** design/osr_rate_gen.sv ***
// Oversampling sample-rate strobe generator
`timescale 1ns/100ps
module osr_rate_gen #(
  parameter int P50   = acq_pkg::OSR_50_CYCLES,
  parameter int P60   = acq_pkg::OSR_60_CYCLES,
  parameter int CNT_W = 14
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic [1:0] sel,
  input  wire logic       osr_active,
  input  wire logic       fast_ready,
  // Strobe
  output logic            strobe_r
);

  logic [CNT_W-1:0] cnt_r;
  logic             fixed;
  logic             period_end;

  always_comb
  begin
    fixed      = osr_active && (sel != 2'h0);
    // At or past the end, so a switch to the shorter period never waits for a wrap
    period_end = sel[1] ? (cnt_r >= CNT_W'(P60 - 1))
                        : (cnt_r >= CNT_W'(P50 - 1));
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= '0;
    else if (!fixed || period_end)
      cnt_r <= '0;
    else
      cnt_r <= cnt_r + CNT_W'(1);
  end

  // Code 00 or no oversampling: fastest rate the sequencer offers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      strobe_r <= 1'b0;
    else
      strobe_r <= fixed ? period_end : fast_ready;
  end

  rate_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    !osr_active |-> ##1 (strobe_r == $past(fast_ready)))
    else $error("strobe not bypassed without oversampling");

endmodule

// *** design/recovery_timer.sv ***
// Recovery delay timer counting 96 us steps
`timescale 1ns/100ps
module recovery_timer #(
  parameter int STEP  = acq_pkg::STEP_CYCLES,
  parameter int PRE_W = 12
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Request
  input  wire logic       start,
  input  wire logic [7:0] steps,
  // Status
  output logic            busy_r,
  output logic            done_r
);

  logic [PRE_W-1:0] pre_r;
  logic [7:0]       left_r;
  logic             step_end;

  assign step_end = (pre_r == PRE_W'(STEP - 1));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      pre_r  <= '0;
      left_r <= 8'h00;
    end
    else if (!busy_r)
    begin
      pre_r  <= '0;
      left_r <= steps;
      busy_r <= start && (steps != 8'h00);
      done_r <= start && (steps == 8'h00);
    end
    else if (step_end)
    begin
      pre_r  <= '0;
      left_r <= left_r - 8'h01;
      busy_r <= (left_r != 8'h01);
      done_r <= (left_r == 8'h01);
    end
    else
    begin
      pre_r  <= pre_r + PRE_W'(1);
      done_r <= 1'b0;
    end
  end

endmodule

// *** test/acquisition_config_regs_bench.sv ***
// Self-checking bench for the acquisition configuration register bank
`timescale 1ns/100ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (a), (e)); end end
module acquisition_config_regs_bench;
  ////////////////////////////////////////////////////////////////////////////
  logic        ref_clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [9:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0]  avs_byteenable;
  logic        seq_end, acquisition_active, fast_sample_ready, adc_result_valid;
  logic        comp_result_valid, comp_above_upper, comp_below_lower;
  logic        manual_measure_req, auto_pair_done;
  logic [11:0] adc_result;
  logic        adc_force_zero, adc_force_full, comp_test_run, cal_apply;
  logic        thermistor_switch_on, osr_sample_strobe, recovery_busy, recovery_done, irq;
  logic [15:0] v, w;
  int          n_fail, total_checks, cyc, n, i;
  // Shortened rate periods so the strobe spacing is quick to measure
  localparam int P50 = 20;
  localparam int P60 = 16;
  logic [9:0]  ctx_t [4] = '{10'h040, 10'h0C0, 10'h200, 10'h280};
  logic [15:0] dly_t [4] = '{16'h0100, 16'h0001, 16'h00FF, 16'hFF00};

  acquisition_config_regs #(.OSR_50_CYCLES(P50), .OSR_60_CYCLES(P60)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .seq_end(seq_end),
    .acquisition_active(acquisition_active), .fast_sample_ready(fast_sample_ready),
    .adc_result(adc_result), .adc_result_valid(adc_result_valid),
    .comp_result_valid(comp_result_valid), .comp_above_upper(comp_above_upper),
    .comp_below_lower(comp_below_lower), .manual_measure_req(manual_measure_req),
    .auto_pair_done(auto_pair_done), .adc_force_zero(adc_force_zero),
    .adc_force_full(adc_force_full), .comp_test_run(comp_test_run), .cal_apply(cal_apply),
    .thermistor_switch_on(thermistor_switch_on), .osr_sample_strobe(osr_sample_strobe),
    .recovery_busy(recovery_busy), .recovery_done(recovery_done), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      finish_test();
    end
  end

  task finish_test;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Holds the request until waitrequest is sampled low, then releases it
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [15:0] d);
    logic [15:0] junk;
    junk = 16'($urandom);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {junk, d};
    avs_byteenable <= 4'hF;
    // No wait limit here: only the cycle ceiling ends a hung access
    do
      @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 16'h0000);
    `CHK(rd, e)
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return adc_force_zero;
      1: return adc_force_full;
      2: return comp_test_run;
      3: return recovery_done;
      4: return osr_sample_strobe;
      default: return irq;
    endcase
  endfunction

  task automatic wait_out(input int s, input logic e, input int lim, output int k);
    k = 0;
    while (pick(s) !== e && k < lim)
    begin
      @(posedge ref_clk);
      k++;
    end
    `CHK(pick(s), e)
  endtask

  task automatic pulse(input int s);
    case (s)
      0: seq_end <= 1'b1;
      1: adc_result_valid <= 1'b1;
      2: comp_result_valid <= 1'b1;
      3: manual_measure_req <= 1'b1;
      4: auto_pair_done <= 1'b1;
      default: fast_sample_ready <= 1'b1;
    endcase
    @(posedge ref_clk);
    {seq_end, adc_result_valid, comp_result_valid} <= 3'h0;
    {manual_measure_req, auto_pair_done, fast_sample_ready} <= 3'h0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rst_n, avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
    {seq_end, acquisition_active, fast_sample_ready, adc_result_valid} = '0;
    {comp_result_valid, comp_above_upper, comp_below_lower, adc_result} = '0;
    {manual_measure_req, auto_pair_done} = '0;
    n = $urandom(32'h6dd5);
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd_chk(8'h62, {16'h0000, acq_pkg::ACQ_CFG_RST});
    rd_chk(8'h63, {16'h0000, acq_pkg::BAL_DLY_RST});
    bus(1'b1, 8'h10, 16'hFFFF);
    rd_chk(8'h10, 32'h0000_0000);
    for (i = 0; i < 12; i++)
    begin
      v = 16'($urandom);
      w = 16'($urandom);
      if (i < 4)
        v[10:9] = i[1:0];
      acquisition_active <= 1'($urandom);
      bus(1'b1, 8'h62, v);
      bus(1'b1, 8'h63, w);
      `CHK(cal_apply, v[14])
      `CHK(thermistor_switch_on, v[10] ? v[9] : acquisition_active)
      rd_chk(8'h62, {16'h0000, v & 16'hFE00});
      rd_chk(8'h63, {16'h0000, w});
    end
    // Zero-scale wrong, full-scale right, comparator over bracket
    bus(1'b1, 8'h72, 16'h0001);
    bus(1'b1, 8'h62, 16'hA000);
    bus(1'b1, 8'h70, 16'h001F);
    pulse(0);
    wait_out(0, 1'b1, 8, n);
    adc_result <= 12'h001;
    pulse(1);
    wait_out(1, 1'b1, 8, n);
    `CHK(adc_force_zero, 1'b0)
    adc_result <= 12'hFFF;
    pulse(1);
    wait_out(2, 1'b1, 8, n);
    comp_above_upper <= 1'b1;
    pulse(2);
    comp_above_upper <= 1'b0;
    wait_out(2, 1'b0, 8, n);
    rd_chk(8'h70, 32'h0000_0005);
    bus(1'b1, 8'h71, 16'h0000);
    `CHK(irq, 1'b0)
    bus(1'b1, 8'h71, 16'h001F);
    wait_out(5, 1'b1, 4, n);
    bus(1'b1, 8'h70, 16'h0005);
    wait_out(5, 1'b0, 4, n);
    // Comparator-only scan skips the ADC test
    bus(1'b1, 8'h72, 16'h0002);
    pulse(0);
    wait_out(2, 1'b1, 8, n);
    `CHK(adc_force_zero, 1'b0)
    comp_below_lower <= 1'b1;
    pulse(2);
    comp_below_lower <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rd_chk(8'h70, 32'h0000_0008);
    bus(1'b1, 8'h71, 16'h0000);
    // The two manual cases zero the unused delay field; the two auto cases zero the selected one
    for (i = 0; i < 4; i++)
    begin
      bus(1'b1, 8'h63, dly_t[i]);
      bus(1'b1, 8'h72, {6'h00, ctx_t[i]});
      pulse(ctx_t[i][6] ? 3 : 4);
      @(posedge ref_clk);
      `CHK(recovery_busy, i < 2)
      wait_out(3, 1'b1, 3000, n);
      if (i < 2)
        `CHK(n, acq_pkg::STEP_CYCLES + 1)
      else
        `CHK(n, 1)
    end
    // Under alert still pending, plus the recovery done bit
    rd_chk(8'h70, 32'h0000_0018);
    // Fixed rates only while oversampling is active
    bus(1'b1, 8'h72, 16'h0008);
    for (i = 1; i < 4; i++)
    begin
      bus(1'b1, 8'h62, {3'h0, i[1:0], 11'h000});
      wait_out(4, 1'b1, 40, n);
      @(posedge ref_clk);
      wait_out(4, 1'b1, 40, n);
      `CHK(n + 1, (i == 1) ? P50 : P60)
    end
    for (i = 0; i < 2; i++)
    begin
      bus(1'b1, 8'h72, i ? 16'h0000 : 16'h0008);
      bus(1'b1, 8'h62, i ? 16'h0800 : 16'h0000);
      pulse(5);
      @(posedge ref_clk);
      `CHK(osr_sample_strobe, 1'b1)
    end
    finish_test();
  end
endmodule
